// file: design/ddr_consts.svh
`ifndef DDR_CONSTS_SVH
`define DDR_CONSTS_SVH

// frame lengths in serial clocks, and the bit-count ceiling
`define DDR_FRAME_BITS      6'h18
`define DDR_FRAME_BITS_CHK  6'h20
`define DDR_CNT_MAX         6'h21

// field positions inside a 24-bit frame
`define DDR_RW_BIT    23
`define DDR_DEV_HI    22
`define DDR_DEV_LO    21
`define DDR_DEST_HI   20
`define DDR_DEST_LO   18
`define DDR_CHAN_HI   17
`define DDR_CHAN_LO   16
`define DDR_DATA_HI   15
`define DDR_DATA_LO   0

// reset values of the per-channel registers
`define DDR_CODE_RST  16'h0000
`define DDR_GAIN_RST  16'hFFFF
`define DDR_OFS_RST   16'h8000
`define DDR_CLR_RST   16'h0000

`endif

// file: design/ddr_pkg.sv
package ddr_pkg;

	typedef logic [15:0]       ddr_word_type;
	typedef logic [3:0][15:0]  ddr_bank_type;

	// destination select codes; 3'h1 has no meaning
	typedef enum logic [2:0] {
		DEST_DATA     = 3'b000,
		DEST_GAIN     = 3'b010,
		DEST_GAIN_ALL = 3'b011,
		DEST_OFS      = 3'b100,
		DEST_OFS_ALL  = 3'b101,
		DEST_CLR      = 3'b110,
		DEST_CTRL     = 3'b111
	} ddr_dest_type;

	typedef enum logic {
		RX_IDLE  = 1'b0,
		RX_SHIFT = 1'b1
	} ddr_rx_state_type;

	// channel field to one-hot write strobe
	function automatic logic [3:0] ddr_chan_onehot(input logic [1:0] chan);
		ddr_chan_onehot = 4'h1 << chan;
	endfunction

endpackage

// file: design/ddr_frame_rx.sv
`timescale 1ns/1ns
`include "ddr_consts.svh"

module ddr_frame_rx
	import ddr_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// serial pins
	input  wire logic        sclk_pin,
	input  wire logic        sync_n_pin,
	input  wire logic        sdin_pin,
	// frame length select, same clock domain
	input  wire logic        long_frame,
	// received frame
	output logic             frame_valid_q,
	output logic [23:0]      frame_q
);

	logic [2:0]        sclk_sy_q;
	logic [2:0]        sync_sy_q;
	logic [1:0]        sdin_sy_q;
	logic [31:0]       shift_q;
	logic [5:0]        cnt_q;
	ddr_rx_state_type  state_q;

	// the first stage feeds only the second; edges come from stages two and three
	wire sclk_fall  = sclk_sy_q[2] & ~sclk_sy_q[1];
	wire sync_fall  = sync_sy_q[2] & ~sync_sy_q[1];
	wire sync_rise  = ~sync_sy_q[2] & sync_sy_q[1];
	wire [5:0] need = long_frame ? `DDR_FRAME_BITS_CHK : `DDR_FRAME_BITS;
	// only an exact bit count is a frame; a short or long burst is dropped
	wire len_ok     = (cnt_q == need);
	wire [23:0] fr  = long_frame ? shift_q[31:8] : shift_q[23:0];

	// pin synchronisers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclk_sy_q <= 3'h7; // idle high, so no false edge after reset
			sync_sy_q <= 3'h7;
			sdin_sy_q <= 2'h0;
		end else begin
			sclk_sy_q <= {sclk_sy_q[1:0], sclk_pin};
			sync_sy_q <= {sync_sy_q[1:0], sync_n_pin};
			sdin_sy_q <= {sdin_sy_q[0], sdin_pin};
		end
	end

	// data is taken on the falling serial edge, msb first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q       <= RX_IDLE;
			cnt_q         <= 6'h0;
			shift_q       <= 32'h0;
			frame_valid_q <= 1'b0;
			frame_q       <= 24'h0;
		end else begin
			frame_valid_q <= 1'b0;
			unique case (state_q)
				RX_IDLE: begin
					if (sync_fall) begin
						state_q <= RX_SHIFT;
						cnt_q   <= 6'h0;
					end
				end
				RX_SHIFT: begin
					if (sync_rise) begin
						state_q       <= RX_IDLE;
						frame_valid_q <= len_ok;
						frame_q       <= fr;
					end else if (sclk_fall) begin
						shift_q <= {shift_q[30:0], sdin_sy_q[1]};
						if (cnt_q != `DDR_CNT_MAX)
							cnt_q <= cnt_q + 6'h1;
					end
				end
			endcase
		end
	end

	// a frame is only released when framing ends
	frame_at_end_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_valid_q |-> $past(sync_rise) && $past(state_q) == RX_SHIFT)
		else $error("frame released without end of framing");

	frame_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_valid_q |=> !frame_valid_q)
		else $error("frame strobe longer than one cycle");

endmodule // ddr_frame_rx

// file: design/ddr_data_regs.sv
`timescale 1ns/1ns
`include "ddr_consts.svh"

// How it works
// - A frame is 24 bits; 32 with error check, last 8 the code.
// - Bit 23 read/write, 22:21 device, 20:18 destination, 17:16 channel, 15:0 data.
// - Act only when device field matches the two address pins.
// - Destination 000 writes the output code of one channel.
// - Channel field 00..11 picks A..D; ignored when no channel is used.
// - Destination 010 writes the gain trim of the named channel.
// - Destination 011 writes the gain trim of all four channels.
// - Each channel holds a 16-bit gain trim in single-LSB steps.
// - Gain trim is straight binary, 0 to 65,535 LSBs.
// - Gain trim resets to all ones.
// - Destination 100 writes the offset trim of the named channel.
// - Destination 101 writes the offset trim of all four channels.
// - Each channel holds a 16-bit offset trim, -32,768 to +32,767 LSBs.
// - Offset trim is straight binary, all zeros the most negative step.
// - Offset trim resets to midscale, meaning zero offset.
// - Destination 110 writes the clear value of the named channel.
// - Clear values reset to zero.
// - Clear input loads clear values only into channels enabled for it.
// - Destination 111 writes no data register; goes to control decode.

module ddr_data_regs
	import ddr_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// serial interface pins
	input  wire logic         sclk_pin,
	input  wire logic         sync_n_pin,
	input  wire logic         sdin_pin,
	// hardware address pins
	input  wire logic         hw_address_pin_hi,
	input  wire logic         hw_address_pin_lo,
	// clear pin, active high
	input  wire logic         clear_pin,
	// settings from the control registers, same clock domain
	input  wire logic [3:0]   clear_enable,
	input  wire logic         frame_error_check,
	// per-channel registers
	output ddr_bank_type      channel_output_code_q,
	output ddr_bank_type      channel_gain_trim_q,
	output ddr_bank_type      channel_offset_trim_q,
	output ddr_bank_type      channel_clear_value_q,
	// frames handed to the control-register decode
	output logic              ctrl_frame_valid_q,
	output logic [23:0]       ctrl_frame_q
);

	logic              frame_valid;
	logic [23:0]       frame;
	logic [1:0]        addr_hi_sy_q;
	logic [1:0]        addr_lo_sy_q;
	logic [1:0]        clear_sy_q;

	// serial frame capture
	ddr_frame_rx u_rx (
		.clk           (clk),
		.rst_n         (rst_n),
		.sclk_pin      (sclk_pin),
		.sync_n_pin    (sync_n_pin),
		.sdin_pin      (sdin_pin),
		.long_frame    (frame_error_check),
		.frame_valid_q (frame_valid),
		.frame_q       (frame)
	);

	// address and clear pins come from outside; two stages each
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr_hi_sy_q <= 2'h0;
			addr_lo_sy_q <= 2'h0;
			clear_sy_q   <= 2'h0;
		end else begin
			addr_hi_sy_q <= {addr_hi_sy_q[0], hw_address_pin_hi};
			addr_lo_sy_q <= {addr_lo_sy_q[0], hw_address_pin_lo};
			clear_sy_q   <= {clear_sy_q[0], clear_pin};
		end
	end

	// frame fields
	wire               rw_flag  = frame[`DDR_RW_BIT];
	wire [1:0]         dev_sel  = frame[`DDR_DEV_HI:`DDR_DEV_LO];
	wire [2:0]         dest_raw = frame[`DDR_DEST_HI:`DDR_DEST_LO];
	wire [1:0]         chan_sel = frame[`DDR_CHAN_HI:`DDR_CHAN_LO];
	ddr_word_type      payload;
	assign payload = frame[`DDR_DATA_HI:`DDR_DATA_LO];
	ddr_dest_type      dest;
	assign dest = ddr_dest_type'(dest_raw);

	// device match against the synchronised address pins
	wire dev_match = (dev_sel == {addr_hi_sy_q[1], addr_lo_sy_q[1]});
	// reads are not served here, so a frame with the flag high writes no bank; a control frame still passes on
	wire wr_ok     = frame_valid & dev_match & ~rw_flag;
	wire clr_level = clear_sy_q[1];

	// destination decode; the unused code 001 selects nothing
	wire wr_code     = wr_ok & (dest == DEST_DATA);
	wire wr_gain     = wr_ok & (dest == DEST_GAIN);
	wire wr_gain_all = wr_ok & (dest == DEST_GAIN_ALL);
	wire wr_ofs      = wr_ok & (dest == DEST_OFS);
	wire wr_ofs_all  = wr_ok & (dest == DEST_OFS_ALL);
	wire wr_clr      = wr_ok & (dest == DEST_CLR);
	wire to_ctrl     = frame_valid & dev_match & (dest == DEST_CTRL);

	// channel strobes; broadcast codes ignore the channel field
	wire [3:0] chan_hot = ddr_chan_onehot(chan_sel);
	wire [3:0] code_we  = wr_code ? chan_hot : 4'h0;
	wire [3:0] gain_we  = (wr_gain ? chan_hot : 4'h0) | {4{wr_gain_all}};
	wire [3:0] ofs_we   = (wr_ofs ? chan_hot : 4'h0) | {4{wr_ofs_all}};
	wire [3:0] clr_we   = wr_clr ? chan_hot : 4'h0;
	// clear is held while the pin is high, and it outranks a data write
	wire [3:0] clr_take = {4{clr_level}} & clear_enable;

	// next values of the four register banks
	ddr_bank_type code_d;
	ddr_bank_type gain_d;
	ddr_bank_type ofs_d;
	ddr_bank_type clrv_d;

	always_comb begin
		code_d = channel_output_code_q;
		gain_d = channel_gain_trim_q;
		ofs_d  = channel_offset_trim_q;
		clrv_d = channel_clear_value_q;
		for (int i = 0; i < 4; i++) begin
			if (clr_take[i])
				code_d[i] = channel_clear_value_q[i];
			else if (code_we[i])
				code_d[i] = payload;
			// trims are stored as raw straight binary codes
			if (gain_we[i])
				gain_d[i] = payload;
			if (ofs_we[i])
				ofs_d[i] = payload;
			if (clr_we[i])
				clrv_d[i] = payload;
		end
	end

	// register banks; every bank resets all four channels to its own default
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			channel_output_code_q <= {4{`DDR_CODE_RST}};
			channel_gain_trim_q   <= {4{`DDR_GAIN_RST}};
			channel_offset_trim_q <= {4{`DDR_OFS_RST}};
			channel_clear_value_q <= {4{`DDR_CLR_RST}};
		end else begin
			channel_output_code_q <= code_d;
			channel_gain_trim_q   <= gain_d;
			channel_offset_trim_q <= ofs_d;
			channel_clear_value_q <= clrv_d;
		end
	end

	// control frames pass on whole; the sub-decode sits elsewhere
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_frame_valid_q <= 1'b0;
			ctrl_frame_q       <= 24'h0;
		end else begin
			ctrl_frame_valid_q <= to_ctrl;
			if (to_ctrl)
				ctrl_frame_q <= frame;
		end
	end

	// ---- checks ----

	// 16-bit lane mask over a bank, one lane per set bit
	function automatic logic [63:0] lane_mask(input logic [3:0] lanes);
		for (int i = 0; i < 4; i++)
			lane_mask[16 * i +: 16] = {16{lanes[i]}};
	endfunction

	sequence frame_hits(ddr_dest_type d);
		frame_valid && dev_match && !rw_flag && dest == d;
	endsequence

	sequence clear_idle;
		!clr_level;
	endsequence

	property bank_single(ddr_dest_type d, ddr_bank_type bank);
		@(posedge clk) disable iff (!rst_n)
		frame_hits(d) |=> bank[$past(chan_sel)] == $past(payload);
	endproperty

	code_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		(frame_hits(DEST_DATA) ##0 clear_idle) |=>
			channel_output_code_q[$past(chan_sel)] == $past(payload))
		else $error("output code write lost");

	gain_single_a: assert property (bank_single(DEST_GAIN, channel_gain_trim_q))
		else $error("gain trim write lost");

	gain_only_one_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_hits(DEST_GAIN) |=>
			((channel_gain_trim_q ^ $past(channel_gain_trim_q)) &
			~lane_mask($past(chan_hot))) == 64'h0)
		else $error("gain write touched another channel");

	gain_all_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_hits(DEST_GAIN_ALL) |=>
			channel_gain_trim_q == {4{$past(payload)}})
		else $error("gain broadcast incomplete");

	ofs_single_a: assert property (bank_single(DEST_OFS, channel_offset_trim_q))
		else $error("offset trim write lost");

	ofs_all_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_hits(DEST_OFS_ALL) |=>
			channel_offset_trim_q == {4{$past(payload)}})
		else $error("offset broadcast incomplete");

	clr_value_a: assert property (bank_single(DEST_CLR, channel_clear_value_q))
		else $error("clear value write lost");

	reset_vals_a: assert property (@(posedge clk)
		!rst_n |=> channel_gain_trim_q == {4{`DDR_GAIN_RST}} &&
			channel_offset_trim_q == {4{`DDR_OFS_RST}} &&
			channel_clear_value_q == {4{`DDR_CLR_RST}})
		else $error("register bank reset value wrong");

	foreign_dev_a: assert property (@(posedge clk) disable iff (!rst_n)
		(frame_valid && !dev_match) |=>
			$stable(channel_gain_trim_q) && $stable(channel_offset_trim_q) &&
			$stable(channel_clear_value_q) && !ctrl_frame_valid_q)
		else $error("frame for another device acted on");

	ctrl_route_a: assert property (@(posedge clk) disable iff (!rst_n)
		(frame_valid && dev_match && dest == DEST_CTRL) |=>
			ctrl_frame_valid_q && ctrl_frame_q == $past(frame) &&
			$stable(channel_gain_trim_q) && $stable(channel_offset_trim_q))
		else $error("control frame misrouted");

	clear_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
		clr_level |=> (channel_output_code_q & {{16{$past(clear_enable[3])}},
			{16{$past(clear_enable[2])}}, {16{$past(clear_enable[1])}},
			{16{$past(clear_enable[0])}}}) == ($past(channel_clear_value_q) &
			{{16{$past(clear_enable[3])}}, {16{$past(clear_enable[2])}},
			{16{$past(clear_enable[1])}}, {16{$past(clear_enable[0])}}}))
		else $error("clear not applied to enabled channel");

	no_frame_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!frame_valid && !clr_level) |=> $stable(channel_output_code_q) &&
			$stable(channel_gain_trim_q) && $stable(channel_offset_trim_q))
		else $error("register changed without a frame");

	// a single-channel write reaches only its own lane
	code_only_one_a: assert property (@(posedge clk) disable iff (!rst_n)
		(frame_hits(DEST_DATA) ##0 clear_idle) |=>
			((channel_output_code_q ^ $past(channel_output_code_q)) &
			~lane_mask($past(chan_hot))) == 64'h0)
		else $error("output code write touched another channel");

	ofs_only_one_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_hits(DEST_OFS) |=>
			((channel_offset_trim_q ^ $past(channel_offset_trim_q)) &
			~lane_mask($past(chan_hot))) == 64'h0)
		else $error("offset write touched another channel");

	clr_only_one_a: assert property (@(posedge clk) disable iff (!rst_n)
		frame_hits(DEST_CLR) |=>
			((channel_clear_value_q ^ $past(channel_clear_value_q)) &
			~lane_mask($past(chan_hot))) == 64'h0)
		else $error("clear value write touched another channel");

	// a channel left out of the clear enables keeps its code
	clear_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
		(clr_level && !frame_valid) |=>
			((channel_output_code_q ^ $past(channel_output_code_q)) &
			~lane_mask($past(clear_enable))) == 64'h0)
		else $error("clear reached a disabled channel");

	trims_no_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(clr_level && !frame_valid) |=> $stable(channel_gain_trim_q) &&
			$stable(channel_offset_trim_q) && $stable(channel_clear_value_q))
		else $error("clear disturbed a trim or clear value");

	// no readback here, so a frame with the flag high leaves the banks alone
	read_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		(frame_valid && rw_flag) |=> $stable(channel_gain_trim_q) &&
			$stable(channel_offset_trim_q) && $stable(channel_clear_value_q))
		else $error("frame with read flag wrote a register");

	unused_dest_a: assert property (@(posedge clk) disable iff (!rst_n)
		(frame_valid && dest_raw == 3'b001) |=> $stable(channel_gain_trim_q) &&
			$stable(channel_offset_trim_q) && $stable(channel_clear_value_q) &&
			!ctrl_frame_valid_q)
		else $error("unused destination code acted on");

	// banks hold unless their own destination is decoded; the output codes also change on a clear
	gain_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(wr_gain || wr_gain_all) |=> $stable(channel_gain_trim_q))
		else $error("gain trim changed without a gain frame");

	ofs_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(wr_ofs || wr_ofs_all) |=> $stable(channel_offset_trim_q))
		else $error("offset trim changed without an offset frame");

	clrv_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!wr_clr |=> $stable(channel_clear_value_q))
		else $error("clear value changed without a clear frame");

	code_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!clr_level && !wr_code) |=> $stable(channel_output_code_q))
		else $error("output code changed without a data frame");

	// the control output pulses only for a control frame and then holds
	ctrl_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(frame_valid && dev_match && dest == DEST_CTRL) |=> !ctrl_frame_valid_q)
		else $error("control strobe without a control frame");

	ctrl_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_frame_valid_q |-> $stable(ctrl_frame_q))
		else $error("control frame changed without its strobe");

	// each bank comes out of reset at its own default
	code_reset_a: assert property (@(posedge clk)
		!rst_n |=> channel_output_code_q == {4{`DDR_CODE_RST}})
		else $error("output code reset value wrong");

	ofs_reset_a: assert property (@(posedge clk)
		!rst_n |=> channel_offset_trim_q == {4{`DDR_OFS_RST}})
		else $error("offset trim reset value wrong");

	clr_reset_a: assert property (@(posedge clk)
		!rst_n |=> channel_clear_value_q == {4{`DDR_CLR_RST}})
		else $error("clear value reset value wrong");

endmodule // ddr_data_regs

// file: testbench/ddr_host_model.sv
`timescale 1ns/1ns

// serial host that sends write frames, msb first, with margin on every phase
module ddr_host_model (
	// pacing clock
	input  wire logic clk,
	// serial pins
	output logic      sclk_pin,
	output logic      sync_n_pin,
	output logic      sdin_pin
);
	// idle: clock and sync high, as both frame edges need a high clock
	initial begin
		sclk_pin = 1'b1;
		sync_n_pin = 1'b1;
		sdin_pin = 1'b0;
	end

	task automatic pace(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// 4-clk phases leave one cycle of margin over the 3-cycle minimum
	task automatic send(input logic [31:0] word, input int nbits);
		sync_n_pin = 1'b0;
		pace(4);
		for (int i = nbits - 1; i >= 0; i--) begin
			sdin_pin = word[i];
			pace(2);
			sclk_pin = 1'b0;
			pace(4);
			sclk_pin = 1'b1;
			pace(2);
		end
		sync_n_pin = 1'b1;
		sdin_pin = ~sdin_pin; // released line must not keep the last bit
		pace(4);
	endtask
endmodule // ddr_host_model

// file: testbench/test_dac_data_reg_write_decode.sv
`timescale 1ns/1ns

module test_dac_data_reg_write_decode
	import ddr_pkg::*;
();
	// clock, reset and pins
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         sclk_pin;
	logic         sync_n_pin;
	logic         sdin_pin;
	logic         clear_pin = 1'b0;
	logic [3:0]   clear_enable = 4'h0;
	logic [1:0]   hw_addr = 2'b10;
	logic         long_mode = 1'b0;
	ddr_bank_type code;
	ddr_bank_type gain;
	ddr_bank_type ofs;
	ddr_bank_type clr;
	logic         ctrl_valid;
	logic [23:0]  ctrl_frame;
	ddr_bank_type exp_q [4];
	int           n_errors = 0;
	int           compares = 0;
	int           ctrl_seen = 0;

	always #4 clk = ~clk;

	ddr_host_model host (.clk(clk), .sclk_pin(sclk_pin), .sync_n_pin(sync_n_pin),
		.sdin_pin(sdin_pin));

	// address pins start at 2'b10; one scenario moves them
	ddr_data_regs dut (.clk(clk), .rst_n(rst_n), .sclk_pin(sclk_pin),
		.sync_n_pin(sync_n_pin), .sdin_pin(sdin_pin), .hw_address_pin_hi(hw_addr[1]),
		.hw_address_pin_lo(hw_addr[0]), .clear_pin(clear_pin), .clear_enable(clear_enable),
		.frame_error_check(long_mode), .channel_output_code_q(code),
		.channel_gain_trim_q(gain), .channel_offset_trim_q(ofs),
		.channel_clear_value_q(clr), .ctrl_frame_valid_q(ctrl_valid),
		.ctrl_frame_q(ctrl_frame));

	// the control pulse lasts one cycle, so count it as it passes
	always @(posedge clk)
		if (ctrl_valid === 1'b1) ctrl_seen++;

	task automatic check(input logic [23:0] seen, input logic [23:0] expv);
		compares++;
		if (seen !== expv) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// write frame: rw low, device field matching the strapped pins
	function automatic logic [23:0] mk(input logic [2:0] dest, input logic [1:0] ch,
		input logic [15:0] data);
		mk = {1'b0, 2'b10, dest, ch, data};
	endfunction

	// 8 clk after the host's tail add margin over the 4 clk decode latency
	task automatic xfer(input logic [31:0] word, input int nbits);
		host.send(word, nbits);
		repeat (8) @(posedge clk);
		#1;
	endtask

	task automatic check_regs;
		for (int c = 0; c < 4; c++) begin
			check({8'h00, code[c]}, {8'h00, exp_q[0][c]});
			check({8'h00, gain[c]}, {8'h00, exp_q[1][c]});
			check({8'h00, ofs[c]}, {8'h00, exp_q[2][c]});
			check({8'h00, clr[c]}, {8'h00, exp_q[3][c]});
		end
	endtask

	task automatic t_reset;
		for (int c = 0; c < 4; c++) begin
			exp_q[0][c] = 16'h0000;
			exp_q[1][c] = 16'hFFFF;
			exp_q[2][c] = 16'h8000;
			exp_q[3][c] = 16'h0000;
		end
		check_regs;
		$display("test reset done");
	endtask

	// every single-channel destination on every channel, distinct values
	task automatic t_single;
		ddr_dest_type dests [4] = '{DEST_DATA, DEST_GAIN, DEST_OFS, DEST_CLR};
		logic [15:0]  v;
		for (int d = 0; d < 4; d++)
			for (int c = 0; c < 4; c++) begin
				v = {1'b1, 3'(d + 1), 4'(c), 8'hC3};
				exp_q[d][c] = v;
				xfer({8'h00, mk(dests[d], 2'(c), v)}, 24);
				check_regs;
			end
		$display("test single done");
	endtask

	// broadcasts ignore the channel field; gain kept in the upper half
	task automatic t_bcast;
		xfer({8'h00, mk(DEST_GAIN_ALL, 2'h2, 16'h8000)}, 24);
		xfer({8'h00, mk(DEST_OFS_ALL, 2'h1, 16'hFFFF)}, 24);
		for (int c = 0; c < 4; c++) begin
			exp_q[1][c] = 16'h8000;
			exp_q[2][c] = 16'hFFFF;
		end
		check_regs;
		$display("test broadcast done");
	endtask

	// foreign device, read flag, unused code, short frame; then a control frame
	task automatic t_refuse;
		logic [23:0] bad [3] = '{{1'b0, 2'b01, DEST_GAIN, 2'h0, 16'h1234},
			{1'b1, 2'b10, DEST_GAIN, 2'h0, 16'h1234},
			{1'b0, 2'b10, 3'b001, 2'h0, 16'h1234}};
		logic [23:0] f;
		int          s;
		for (int i = 0; i < 3; i++)
			xfer({8'h00, bad[i]}, 24);
		f = mk(DEST_GAIN, 2'h0, 16'h1234);
		xfer({9'h000, f[23:1]}, 23);
		check_regs;
		s = ctrl_seen;
		f = mk(DEST_CTRL, 2'h3, 16'h2ABC);
		xfer({8'h00, f}, 24);
		check(24'(ctrl_seen - s), 24'h000001);
		check(ctrl_frame, f);
		check_regs;
		$display("test refuse done");
	endtask

	// with checking on, only 32-bit frames count
	task automatic t_long;
		long_mode = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		xfer({mk(DEST_CLR, 2'h3, 16'h7E81), 8'hA5}, 32);
		xfer({8'h00, mk(DEST_CLR, 2'h2, 16'h1111)}, 24);
		exp_q[3][3] = 16'h7E81;
		check_regs;
		long_mode = 1'b0;
		$display("test long frame done");
	endtask

	// the device field follows the address pins when they are moved
	task automatic t_addr;
		logic [23:0] f;
		hw_addr = 2'b01;
		repeat (4) @(posedge clk);
		#1;
		f = {1'b0, 2'b01, DEST_OFS, 2'h1, 16'h5AA5};
		xfer({8'h00, f}, 24);
		xfer({8'h00, mk(DEST_OFS, 2'h2, 16'hA55A)}, 24);
		exp_q[2][1] = 16'h5AA5;
		check_regs;
		hw_addr = 2'b10;
		repeat (4) @(posedge clk);
		#1;
		$display("test address done");
	endtask

	// clear reaches only the enabled channels and the codes keep it after
	task automatic t_clear;
		clear_enable = 4'b0101;
		clear_pin = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		exp_q[0][0] = exp_q[3][0];
		exp_q[0][2] = exp_q[3][2];
		check_regs;
		clear_pin = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		check_regs;
		clear_enable = 4'h0;
		$display("test clear done");
	endtask

	initial begin
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		t_reset;
		t_single;
		t_bcast;
		t_refuse;
		t_long;
		t_addr;
		t_clear;
		end_of_test;
	end

	// about 30 frames of some 210 clk each, with ample margin
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test;
	end
endmodule // test_dac_data_reg_write_decode
